// ==== logic/adc_output_dsp.sv ====
// output path: offset loop, fine gain, decimating FIR, latency, format, mux
// assumes core data stable at each detected rise of the sample clock pin
//
// Design decisions made here: the AXI4-Lite register port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module adc_output_dsp (
  input wire logic aclk,
  input wire logic aresetn,
  input wire dsp_out_pkg::axi_req_t s_axi_req,
  output var dsp_out_pkg::axi_rsp_t s_axi_rsp,
  input wire logic sample_clk_pin,
  input wire dsp_out_pkg::core_sample_t core_sample,
  input wire logic serial_enable_pin,
  input wire logic control_pin_one,
  input wire logic control_pin_two,
  input wire logic control_pin_three,
  output var dsp_out_pkg::out_bus_t out_bus,
  output var logic [2:0] lvds_term_sel
);
  import dsp_out_pkg::*;

  typedef struct packed {
    logic [4:0] s1;
    logic [4:0] s2;
    logic [4:0] s3;
    logic [4:0] lvl;
    logic [9:0] ctrl;
    logic [8:0] dsp;
    logic [6:0] filt;
    coef_set_t coef;
    logic aw_have;
    logic w_have;
    logic [7:0] awaddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    axi_rsp_t rsp;
    logic ev1;
    logic [0:1][1:0] flags;
    logic [0:1][13:0] raw;
    logic [0:1][ACC_W-1:0] acc;
    logic [0:1][0:23][13:0] hist;
    logic [2:0] dec_cnt;
    logic [0:13][32:0] dl;
    logic [13:0] pend_b;
    logic pend;
    out_bus_t bus;
    logic [2:0] term;
  } st_t;

  st_t st_q;
  st_t st_d;

  logic lowlat;
  logic twos;
  logic mux_on;
  logic filt_on;
  logic nodec;
  logic [2:0] rate;
  logic [2:0] dec_last;
  logic [4:0] tc_sh;
  coef_set_t cur_h;
  logic [0:1][13:0] est;
  logic signed [14:0] pair [0:1][0:11];
  logic signed [26:0] prod [0:1][0:11];

  // clamp to the 14-bit range rather than wrap
  function automatic logic [13:0] sat14(input logic signed [31:0] v);
    if (v > SAT_MAX) begin
      return 14'h1fff;
    end else if (v < SAT_MIN) begin
      return 14'h2000;
    end
    return v[13:0];
  endfunction : sat14

  // loop sum scaled by the time constant, then clamped
  function automatic logic [13:0] ofs_est(input logic [ACC_W-1:0] acc,
                                          input logic [4:0] sh);
    logic signed [ACC_W-1:0] e;
    e = $signed(acc) >>> sh;
    if (e > OFS_LIMIT) begin
      return 14'(OFS_LIMIT);
    end else if (e < -OFS_LIMIT) begin
      return 14'(-OFS_LIMIT);
    end
    return e[13:0];
  endfunction : ofs_est

  // positive overdrive wins if both flags are set
  function automatic logic [13:0] out_word(input logic [13:0] v,
                                           input logic [1:0] ov,
                                           input logic tc);
    if (ov[1]) begin
      return tc ? OVR_POS_TC : OVR_POS_OB;
    end else if (ov[0]) begin
      return tc ? OVR_NEG_TC : OVR_NEG_OB;
    end
    return tc ? v : {~v[13], v[12:0]};
  endfunction : out_word

  // user taps come in as an argument so the assign sees them change
  function automatic coef_set_t pick_h(input logic [6:0] f,
                                       input coef_set_t u);
    if (f[FILT_CSEL]) begin
      return u;
    end else if (f[FILT_RATE +: 3] == RATE_D2) begin
      return f[FILT_TYPE] ? D2_HP : D2_LP;
    end
    case (f[FILT_TYPE +: 2])
      2'b00: return D4_LP;
      2'b01: return D4_BP1;
      2'b10: return D4_BP2;
      default: return D4_HP;
    endcase
  endfunction : pick_h

  // unmapped addresses answer with an error, store nothing
  function automatic logic map_hit(input logic [7:0] a);
    logic [7:0] o;
    o = a - REG_COEF0;
    return (a == REG_CTRL) || (a == REG_DSP) || (a == REG_FILT) ||
           (a == REG_STAT_A) || (a == REG_STAT_B) || (a >= REG_COEF0 && o < COEF_SPAN);
  endfunction : map_hit

  // fields sit in the low bits, status mode flag at bit 16; the rest read zero
  function automatic logic [31:0] rd_word(input logic [7:0] a);
    logic [7:0] o;
    logic [31:0] r;
    o = a - REG_COEF0;
    r = '0;
    if (a == REG_CTRL) begin
      r[9:0] = st_q.ctrl;
    end else if (a == REG_DSP) begin
      r[8:0] = st_q.dsp;
    end else if (a == REG_FILT) begin
      r[6:0] = st_q.filt;
    end else if (a == REG_STAT_A) begin
      r[13:0] = est[0];
      r[STAT_MODE_BIT] = mux_on;
    end else if (a == REG_STAT_B) begin
      r[13:0] = est[1];
      r[STAT_MODE_BIT] = filt_on;
    end else if (a >= REG_COEF0 && o < COEF_SPAN) begin
      r[11:0] = st_q.coef[o[5:2]];
    end
    return r;
  endfunction : rd_word

  // mode decode
  assign lowlat = st_q.ctrl[CTRL_LOWLAT];
  assign twos = st_q.ctrl[CTRL_PINCFG] ? st_q.lvl[3] : st_q.ctrl[CTRL_TWOS];
  // pins only count in pin-configuration mode; needs the CMOS interface
  assign mux_on = st_q.ctrl[CTRL_CMOS] && ((st_q.ctrl[CTRL_PD +: 3] == PD_MUX) ||
                  (st_q.ctrl[CTRL_PINCFG] && (&st_q.lvl[2:0])));
  assign rate = st_q.filt[FILT_RATE +: 3];
  assign nodec = !st_q.filt[FILT_EN];
  // decimate-by-8 and no-decimation exist only with user taps
  assign filt_on = !lowlat && ((st_q.filt[FILT_EN] && (rate == RATE_D2 ||
                   rate == RATE_D4 || (rate == RATE_D8 && st_q.filt[FILT_CSEL]))) ||
                   (nodec && rate == RATE_NODEC && st_q.filt[FILT_CSEL]));
  assign dec_last = (rate == RATE_D2) ? 3'd1 : (rate == RATE_D4) ? 3'd3 : 3'd7;
  assign tc_sh = TC_SHIFT[st_q.dsp[DSP_TC +: 3]];
  assign cur_h = pick_h(st_q.filt, st_q.coef);

  // per-channel estimate and symmetric tap pairs
  // no-decimation folds the twelve newest samples onto h6..h11
  for (genvar c = 0; c < 2; c++) begin : g_ch
    assign est[c] = ofs_est(st_q.acc[c], tc_sh);
    for (genvar k = 0; k < 12; k++) begin : g_tap
      if (k < SHORT_HALF) begin : g_short
        assign pair[c][k] = nodec ?
          $signed({st_q.hist[c][k][13], st_q.hist[c][k]}) +
          $signed({st_q.hist[c][11-k][13], st_q.hist[c][11-k]}) :
          $signed({st_q.hist[c][k][13], st_q.hist[c][k]}) +
          $signed({st_q.hist[c][23-k][13], st_q.hist[c][23-k]});
        assign prod[c][k] = $signed(nodec ? cur_h[k+SHORT_HALF] : cur_h[k]) *
                            pair[c][k];
      end else begin : g_long
        assign pair[c][k] = nodec ? 15'sd0 :
          $signed({st_q.hist[c][k][13], st_q.hist[c][k]}) +
          $signed({st_q.hist[c][23-k][13], st_q.hist[c][23-k]});
        assign prod[c][k] = $signed(cur_h[k]) * pair[c][k];
      end
    end
  end

  // every local gets a value first, so nothing latches
  always_comb begin
    logic [4:0] sync_in;
    logic rise;
    logic fall;
    logic [7:0] wa;
    logic [7:0] o;
    logic [31:0] m;
    logic [31:0] mw;
    logic signed [31:0] x;
    logic signed [31:0] d;
    logic signed [31:0] gp;
    logic signed [31:0] facc;
    logic [13:0] corr;
    logic [0:1][13:0] val;
    logic emit;
    logic [32:0] entry;
    logic [32:0] tap;
    logic [13:0] w0;
    logic [13:0] w1;
    sync_in = {sample_clk_pin, serial_enable_pin, control_pin_three,
               control_pin_two, control_pin_one};
    rise = 1'b0;
    fall = 1'b0;
    wa = '0;
    o = '0;
    m = '0;
    mw = '0;
    x = '0;
    d = '0;
    gp = '0;
    facc = '0;
    corr = '0;
    val = '0;
    emit = 1'b0;
    entry = '0;
    tap = '0;
    w0 = '0;
    w1 = '0;
    st_d = st_q;

    // three-stage pin capture, change accepted when stages 2 and 3 agree
    st_d.s1 = sync_in;
    st_d.s2 = st_q.s1;
    st_d.s3 = st_q.s2;
    st_d.lvl = (~(st_q.s2 ^ st_q.s3) & st_q.s3) | ((st_q.s2 ^ st_q.s3) & st_q.lvl);
    rise = st_d.lvl[4] && !st_q.lvl[4];
    fall = !st_d.lvl[4] && st_q.lvl[4];

    // register bus: address and data taken in either order
    if (st_q.rsp.awready && s_axi_req.awvalid) begin
      st_d.aw_have = 1'b1;
      st_d.awaddr = s_axi_req.awaddr;
    end
    if (st_q.rsp.wready && s_axi_req.wvalid) begin
      st_d.w_have = 1'b1;
      st_d.wdata = s_axi_req.wdata;
      st_d.wstrb = s_axi_req.wstrb;
    end
    if (st_q.rsp.bvalid && s_axi_req.bready) begin
      st_d.rsp.bvalid = 1'b0;
    end
    if (st_q.aw_have && st_q.w_have && !st_q.rsp.bvalid) begin
      wa = {st_q.awaddr[7:2], 2'b00};
      o = wa - REG_COEF0;
      m = {{8{st_q.wstrb[3]}}, {8{st_q.wstrb[2]}}, {8{st_q.wstrb[1]}},
           {8{st_q.wstrb[0]}}};
      // byte lanes merge into the stored value
      mw = (rd_word(wa) & ~m) | (st_q.wdata & m);
      st_d.aw_have = 1'b0;
      st_d.w_have = 1'b0;
      st_d.rsp.bvalid = 1'b1;
      st_d.rsp.bresp = map_hit(wa) ? RESP_OKAY : RESP_SLVERR;
      if (wa == REG_CTRL) begin
        st_d.ctrl = mw[9:0];
      end else if (wa == REG_DSP) begin
        st_d.dsp = mw[8:0];
      end else if (wa == REG_FILT) begin
        st_d.filt = mw[6:0];
      end else if (wa >= REG_COEF0 && o < COEF_SPAN) begin
        st_d.coef[o[5:2]] = mw[11:0];
      end
    end
    // ready stays low from take until the answer is accepted
    st_d.rsp.awready = !st_d.aw_have && !st_d.rsp.bvalid;
    st_d.rsp.wready = !st_d.w_have && !st_d.rsp.bvalid;
    if (st_q.rsp.rvalid && s_axi_req.rready) begin
      st_d.rsp.rvalid = 1'b0;
    end
    if (st_q.rsp.arready && s_axi_req.arvalid) begin
      wa = {s_axi_req.araddr[7:2], 2'b00};
      st_d.rsp.rvalid = 1'b1;
      // read data captured once, stands until rready
      st_d.rsp.rdata = rd_word(wa);
      st_d.rsp.rresp = map_hit(wa) ? RESP_OKAY : RESP_SLVERR;
    end
    // one read in flight at a time
    st_d.rsp.arready = !st_d.rsp.rvalid;

    // sample edge: offset loop, gain, history
    st_d.ev1 = rise;
    if (rise) begin
      for (int c = 0; c < 2; c++) begin
        x = 32'($signed({~core_sample.data[c][13], core_sample.data[c][12:0]}));
        st_d.raw[c] = x[13:0];
        st_d.flags[c] = {core_sample.over_pos[c], core_sample.over_neg[c]};
        if (st_q.dsp[DSP_OFS_EN]) begin
          d = x - 32'($signed(est[c]));
          corr = sat14(d);
          if (!st_q.dsp[DSP_FREEZE]) begin
            st_d.acc[c] = st_q.acc[c] + ACC_W'($signed(corr));
          end
        end else begin
          corr = x[13:0];
          st_d.acc[c] = '0;
        end
        // one positive gain for both channels; unused codes are unity
        gp = $signed(corr) * $signed({1'b0, GAIN_Q[st_q.dsp[DSP_GAIN +: 4]]});
        st_d.hist[c] = {sat14(gp >>> GAIN_FRAC), st_q.hist[c][0:22]};
      end
    end

    // one cycle later: filter, decimate, delay line, drive the buses
    st_d.bus.word_strobe = 1'b0;
    if (st_q.ev1) begin
      emit = nodec || (st_q.dec_cnt == dec_last);
      for (int c = 0; c < 2; c++) begin
        facc = '0;
        for (int k = 0; k < 12; k++) begin
          facc = facc + 32'(prod[c][k]);
        end
        if (filt_on) begin
          val[c] = sat14(facc >>> COEF_FRAC);
        end else if (lowlat) begin
          val[c] = st_q.raw[c];
        end else begin
          val[c] = st_q.hist[c][0];
        end
      end
      st_d.dec_cnt = (filt_on && !nodec && !emit) ? st_q.dec_cnt + 3'd1 : 3'd0;
      // top bit marks an entry the decimator keeps
      entry = {(!filt_on || emit), st_q.flags[0], st_q.flags[1], val[0], val[1]};
      // tap read before the shift gives exactly the chosen latency
      tap = lowlat ? st_q.dl[LAT_LOW-1] : st_q.dl[LAT_DEFAULT-1];
      st_d.dl = {entry, st_q.dl[0:12]};
      if (tap[32]) begin
        w0 = out_word(tap[27:14], tap[31:30], twos);
        w1 = out_word(tap[13:0], tap[29:28], twos);
        st_d.bus.word_strobe = 1'b1;
        st_d.bus.second_is_b = !mux_on;
        if (mux_on) begin
          st_d.bus.second_channel_bus = w0;
          st_d.pend_b = w1;
          st_d.pend = 1'b1;
        end else begin
          st_d.bus.first_channel_bus = w0;
          st_d.bus.second_channel_bus = w1;
          st_d.pend = 1'b0;
        end
      end
    end else if (fall && st_q.pend) begin
      // second half of the sample period carries channel B
      st_d.bus.second_channel_bus = st_q.pend_b;
      st_d.bus.second_is_b = 1'b1;
      st_d.bus.word_strobe = 1'b1;
      st_d.pend = 1'b0;
    end
    st_d.bus.first_bus_release_n = mux_on;
    st_d.term = st_q.ctrl[CTRL_TERM +: 3];
  end

  // sync reset; only ctrl leaves all-zero, loaded with CTRL_RST
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_q <= '0;
      st_q.ctrl <= CTRL_RST;
      st_q.dsp <= DSP_RST;
      st_q.filt <= FILT_RST;
    end else begin
      st_q <= st_d;
    end
  end

  // outputs are plain views of registered state
  assign s_axi_rsp = st_q.rsp;
  assign out_bus = st_q.bus;
  assign lvds_term_sel = st_q.term;
endmodule : adc_output_dsp
`default_nettype wire

// ==== shared/dsp_out_pkg.sv ====
// constants, tables and carrier types for the converter output path
// assumes one 20 MHz bus clock; the sample clock is sampled as a pin
// Function
// - three termination resistors, eight selectable combinations
// - format two's complement or offset binary
// - positive overdrive forces 0x7ff or 0x3ff
// - negative overdrive forces 0x000 or 0x400
// - multiplexed mode only with CMOS, on B bus
// - channel A pins released in multiplexed mode
// - multiplexed mode by field or control pins
// - code 111 or all pins high selects mux
// - latency 14 cycles, 10 in low latency
// - low latency bypasses whole processing block
// - offset estimated and subtracted every sample
// - time constant shift from bits 6..4
// - freeze holds estimate, still applies it
// - offset correction disabled after reset
// - fine gain 0.05 dB steps, codes 0..10
// - positive gain only, same for both channels
// - decimation filter disabled after reset
// - rate field picks 2, 4, 8 or none
// - type bits pick built-in band
// - custom select ignores type, allows 8 and none
// - symmetric 24-tap FIR, scaled by 2^-11
package dsp_out_pkg;
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_DSP = 8'h04;
  localparam logic [7:0] REG_FILT = 8'h08;
  localparam logic [7:0] REG_STAT_A = 8'h0c;
  localparam logic [7:0] REG_STAT_B = 8'h10;
  localparam logic [7:0] REG_COEF0 = 8'h40;
  localparam logic [7:0] COEF_SPAN = 8'h30;
  localparam int CTRL_TWOS = 0;
  localparam int CTRL_LOWLAT = 1;
  localparam int CTRL_CMOS = 2;
  localparam int CTRL_PINCFG = 3;
  localparam int CTRL_PD = 4;
  localparam int CTRL_TERM = 7;
  localparam int DSP_GAIN = 0;
  localparam int DSP_TC = 4;
  localparam int DSP_OFS_EN = 7;
  localparam int DSP_FREEZE = 8;
  localparam int FILT_RATE = 0;
  localparam int FILT_TYPE = 3;
  localparam int FILT_CSEL = 5;
  localparam int FILT_EN = 6;
  localparam int STAT_MODE_BIT = 16;
  localparam logic [9:0] CTRL_RST = 10'h004;
  localparam logic [8:0] DSP_RST = 9'h000;
  localparam logic [6:0] FILT_RST = 7'h00;
  localparam logic [2:0] PD_MUX = 3'b111;
  localparam logic [2:0] RATE_D2 = 3'b000;
  localparam logic [2:0] RATE_D4 = 3'b001;
  localparam logic [2:0] RATE_D8 = 3'b100;
  localparam logic [2:0] RATE_NODEC = 3'b011;
  localparam int LAT_DEFAULT = 14;
  localparam int LAT_LOW = 10;
  localparam int SHORT_HALF = 6;
  localparam int COEF_FRAC = 11;
  localparam int GAIN_FRAC = 14;
  localparam int ACC_W = 44;
  localparam int SAT_MAX = 8191;
  localparam int SAT_MIN = -8192;
  localparam int OFS_LIMIT = 82;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
  localparam logic [13:0] OVR_POS_OB = 14'h07ff;
  localparam logic [13:0] OVR_POS_TC = 14'h03ff;
  localparam logic [13:0] OVR_NEG_OB = 14'h0000;
  localparam logic [13:0] OVR_NEG_TC = 14'h0400;
  // shift per time-constant code, index 7 leftmost
  localparam logic [7:0][4:0] TC_SHIFT = {5'd27, 5'd27, 5'd29, 5'd28,
    5'd24, 5'd25, 5'd26, 5'd27};
  // gain in units of 2^-14; codes above 10 stay at unity
  localparam logic [15:0][16:0] GAIN_Q = {{5{17'd16384}}, 17'd17355,
    17'd17255, 17'd17156, 17'd17058, 17'd16960, 17'd16862, 17'd16766,
    17'd16669, 17'd16574, 17'd16479, 17'd16384};
  typedef logic [0:11][11:0] coef_set_t;
  localparam coef_set_t D2_LP = '{12'sd23, -12'sd37, -12'sd6, 12'sd68,
    -12'sd36, -12'sd61, 12'sd35, 12'sd118, -12'sd100, -12'sd197, 12'sd273, 12'sd943};
  localparam coef_set_t D2_HP = '{-12'sd22, -12'sd65, -12'sd52, 12'sd30,
    12'sd66, -12'sd35, -12'sd107, 12'sd38, 12'sd202, -12'sd41, -12'sd644, 12'sd1061};
  localparam coef_set_t D4_LP = '{-12'sd17, -12'sd50, 12'sd71, 12'sd46,
    12'sd24, -12'sd42, -12'sd100, -12'sd97, 12'sd8, 12'sd202, 12'sd414, 12'sd554};
  localparam coef_set_t D4_BP1 = '{-12'sd7, 12'sd19, -12'sd47, 12'sd127,
    12'sd73, 12'sd0, 12'sd86, 12'sd117, -12'sd190, -12'sd464, -12'sd113, 12'sd526};
  localparam coef_set_t D4_BP2 = '{-12'sd34, -12'sd34, -12'sd101, 12'sd43,
    12'sd58, -12'sd28, -12'sd5, -12'sd179, 12'sd294, 12'sd86, -12'sd563, 12'sd352};
  localparam coef_set_t D4_HP = '{12'sd32, -12'sd15, -12'sd95, 12'sd22,
    -12'sd8, -12'sd81, 12'sd106, -12'sd62, -12'sd97, 12'sd310, -12'sd501, 12'sd575};
  typedef struct packed {
    logic awvalid;
    logic [7:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [7:0] araddr;
    logic rready;
  } axi_req_t;
  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } axi_rsp_t;
  // channel 0 is A, channel 1 is B; data in offset binary from the cores
  typedef struct packed {
    logic [0:1][13:0] data;
    logic [0:1] over_pos;
    logic [0:1] over_neg;
  } core_sample_t;
  typedef struct packed {
    logic [13:0] first_channel_bus;
    logic first_bus_release_n;
    logic [13:0] second_channel_bus;
    logic second_is_b;
    logic word_strobe;
  } out_bus_t;
endpackage : dsp_out_pkg

// ==== sim/adc_output_dsp_props.sv ====
// port assertions for adc_output_dsp
// assumes one aclk domain with synchronous active-low reset
`timescale 1ns/1ps
`default_nettype none
module adc_output_dsp_props (
  input wire logic aclk,
  input wire logic aresetn,
  input wire dsp_out_pkg::axi_req_t s_axi_req,
  input wire dsp_out_pkg::axi_rsp_t s_axi_rsp,
  input wire dsp_out_pkg::out_bus_t out_bus,
  input wire logic [2:0] lvds_term_sel
);
  import dsp_out_pkg::*;
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  property p_strobe;
    out_bus.word_strobe |=> !out_bus.word_strobe;
  endproperty
  a_strobe: assert property (p_strobe) else $error("strobe too long");
  // shared bus: every A word is followed by its B word within eight cycles
  property p_mux_pair;
    out_bus.first_bus_release_n && out_bus.word_strobe && !out_bus.second_is_b
      |-> ##[1:8] out_bus.word_strobe && out_bus.second_is_b;
  endproperty
  a_mux_pair: assert property (p_mux_pair) else $error("no B word");
  property p_term;
    !$stable(lvds_term_sel) |-> s_axi_rsp.bvalid || $past(s_axi_rsp.bvalid);
  endproperty
  a_term: assert property (p_term) else $error("term moved without write");
  property p_bvalid;
    s_axi_req.awvalid && s_axi_rsp.awready && s_axi_req.wvalid && s_axi_rsp.wready
      |=> ##1 s_axi_rsp.bvalid;
  endproperty
  a_bvalid: assert property (p_bvalid) else $error("late write response");
  property p_rvalid;
    s_axi_req.arvalid && s_axi_rsp.arready |=> s_axi_rsp.rvalid && !s_axi_rsp.arready;
  endproperty
  a_rvalid: assert property (p_rvalid) else $error("late read response");
  property p_ready_low;
    s_axi_rsp.bvalid |-> !s_axi_rsp.awready && !s_axi_rsp.wready;
  endproperty
  a_ready_low: assert property (p_ready_low) else $error("write taken while busy");
  property p_rd_busy;
    s_axi_rsp.rvalid |-> !s_axi_rsp.arready;
  endproperty
  a_rd_busy: assert property (p_rd_busy) else $error("read taken while busy");
  property p_slverr;
    s_axi_rsp.rvalid && s_axi_rsp.rresp == RESP_SLVERR |-> s_axi_rsp.rdata == 32'h0;
  endproperty
  a_slverr: assert property (p_slverr) else $error("error read carries data");
  c_mux: cover property (out_bus.word_strobe && out_bus.second_is_b);
  c_slverr: cover property (s_axi_rsp.rvalid && s_axi_rsp.rresp == RESP_SLVERR);
  c_term: cover property (lvds_term_sel == 3'h7);
endmodule : adc_output_dsp_props
`default_nettype wire

// ==== sim/rx_capture.sv ====
// receiving logic model: takes output words at each strobe
// assumes out_bus comes from flops in the aclk domain
`timescale 1ns/1ps
`default_nettype none
module rx_capture (
  input wire logic aclk,
  input wire logic aresetn,
  input wire dsp_out_pkg::out_bus_t out_bus,
  output var int n_words,
  output var logic [13:0] a_word,
  output var logic [13:0] b_word
);
  import dsp_out_pkg::*;
  always @(posedge aclk) begin
    if (!aresetn) begin
      n_words <= 0;
    end else if (out_bus.word_strobe) begin
      n_words <= n_words + 1;
      // second bus carries A then B in shared-bus mode
      if (out_bus.second_is_b) begin
        b_word <= out_bus.second_channel_bus;
      end else begin
        a_word <= out_bus.second_channel_bus;
      end
    end
  end
endmodule : rx_capture
`default_nettype wire

// ==== sim/adc_output_digital_processing_tb_top.sv ====
// bench for adc_output_dsp: register bus, sample link, output bus
// assumes package, design, checker and rx_capture compiled first
`timescale 1ns/1ps
`default_nettype none
module adc_output_digital_processing_tb_top;
  import dsp_out_pkg::*;
  logic aclk = 0;
  logic aresetn = 0;
  axi_req_t s_axi_req = '0;
  axi_rsp_t s_axi_rsp;
  logic sample_clk_pin = 0;
  core_sample_t core_sample = '0;
  core_sample_t next_sample = '0;
  logic serial_enable_pin = 0;
  logic control_pin_one = 0;
  logic control_pin_two = 0;
  logic control_pin_three = 0;
  out_bus_t out_bus;
  logic [2:0] lvds_term_sel;
  int n_words;
  logic [13:0] a_word;
  logic [13:0] b_word;
  int n_fail = 0;
  int tests_run = 0;
  int rise_cnt = 0;
  int cyc = 0;
  int n0;
  logic [1:0] resp;
  logic [31:0] rd;
  logic [13:0] e;
  logic [6:0] dflt [10] = '{7'h40, 7'h48, 7'h41, 7'h49, 7'h51, 7'h59, 7'h44, 7'h64, 7'h23, 7'h41};
  int dnum [10] = '{8, 8, 4, 4, 4, 4, 16, 2, 16, 16};
  logic [13:0] gexp [3] = '{14'h23e8, 14'h2423, 14'h23e8};
  logic [3:0] gcode [3] = '{4'h0, 4'ha, 4'hf};
  always #25 aclk = ~aclk;
  // 2.5 MSPS, well under the shared-bus limit; data changes 300 ns after a rise
  initial begin
    #37;
    forever begin
      sample_clk_pin = 1'b1;
      rise_cnt++;
      #200 sample_clk_pin = 1'b0;
      #100 core_sample = next_sample;
      #100;
    end
  end
  adc_output_dsp dut (.aclk(aclk), .aresetn(aresetn), .s_axi_req(s_axi_req),
    .s_axi_rsp(s_axi_rsp), .sample_clk_pin(sample_clk_pin), .core_sample(core_sample),
    .serial_enable_pin(serial_enable_pin), .control_pin_one(control_pin_one),
    .control_pin_two(control_pin_two), .control_pin_three(control_pin_three),
    .out_bus(out_bus), .lvds_term_sel(lvds_term_sel));
  rx_capture rx (.aclk(aclk), .aresetn(aresetn), .out_bus(out_bus), .n_words(n_words),
    .a_word(a_word), .b_word(b_word));
  task automatic tally_and_finish;
    if (n_fail == 0 && tests_run > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : tally_and_finish
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic axi_write(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    s_axi_req.awvalid <= 1'b1;
    s_axi_req.awaddr <= a;
    s_axi_req.wvalid <= 1'b1;
    s_axi_req.wdata <= d;
    s_axi_req.wstrb <= 4'hf;
    s_axi_req.bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_req.awvalid && s_axi_rsp.awready) s_axi_req.awvalid <= 1'b0;
      if (s_axi_req.wvalid && s_axi_rsp.wready) s_axi_req.wvalid <= 1'b0;
    end while (s_axi_rsp.bvalid !== 1'b1);
    resp = s_axi_rsp.bresp;
    s_axi_req.bready <= 1'b0;
  endtask : axi_write
  task automatic axi_read(input logic [7:0] a);
    @(posedge aclk);
    s_axi_req.arvalid <= 1'b1;
    s_axi_req.araddr <= a;
    s_axi_req.rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_req.arvalid && s_axi_rsp.arready) s_axi_req.arvalid <= 1'b0;
    end while (s_axi_rsp.rvalid !== 1'b1);
    rd = s_axi_rsp.rdata;
    resp = s_axi_rsp.rresp;
    s_axi_req.rready <= 1'b0;
  endtask : axi_read
  task automatic set_in(input logic [13:0] da, input logic [13:0] db, input logic [1:0] p,
      input logic [1:0] n);
    next_sample.data[0] = da;
    next_sample.data[1] = db;
    next_sample.over_pos = p;
    next_sample.over_neg = n;
  endtask : set_in
  task automatic wait_rises(input int n);
    repeat (n) @(posedge sample_clk_pin);
    repeat (7) @(posedge aclk);
  endtask : wait_rises
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_fail++;
      tally_and_finish();
    end
  end
  initial begin
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    axi_read(REG_DSP); check(rd, 32'h0);
    axi_read(REG_FILT); check(rd, 32'h0);
    axi_read(8'h3c); check(32'(resp), 32'(RESP_SLVERR));
    axi_write(8'hfc, 32'h1); check(32'(resp), 32'(RESP_SLVERR));
    for (int i = 0; i < 8; i++) begin
      axi_write(REG_DSP, 32'(i) << 4);
      axi_read(REG_DSP); check(rd, 32'(i) << 4);
      axi_write(REG_CTRL, 32'h4 | (32'(i) << 7));
      repeat (2) @(posedge aclk);
      check(32'(lvds_term_sel), 32'(i));
    end
    for (int f = 0; f < 2; f++) begin
      for (int o = 0; o < 3; o++) begin
        axi_write(REG_CTRL, 32'h6 | 32'(f));
        set_in(14'h1234, 14'h1234, (o == 1) ? 2'b11 : 2'b00, (o == 2) ? 2'b11 : 2'b00);
        wait_rises(14);
        if (o == 1) e = f ? OVR_POS_TC : OVR_POS_OB;
        else if (o == 2) e = f ? OVR_NEG_TC : OVR_NEG_OB;
        else e = f ? 14'h3234 : 14'h1234;
        check(32'(out_bus.first_channel_bus), 32'(e));
        check(32'(out_bus.second_channel_bus), 32'(e));
      end
    end
    axi_write(REG_CTRL, 32'h4);
    set_in(14'h23e8, 14'h23e8, 2'b00, 2'b00);
    for (int g = 0; g < 3; g++) begin
      axi_write(REG_DSP, 32'(gcode[g]));
      wait_rises(20);
      check(32'(out_bus.first_channel_bus), 32'(gexp[g]));
      check(32'(out_bus.second_channel_bus), 32'(gexp[g]));
    end
    axi_write(REG_DSP, 32'ha);
    axi_write(REG_CTRL, 32'h6);
    wait_rises(14);
    check(32'(out_bus.first_channel_bus), 32'h23e8);
    axi_write(REG_DSP, 32'h0);
    for (int ll = 0; ll < 2; ll++) begin
      axi_write(REG_CTRL, 32'h4 | (32'(ll) << 1));
      set_in(14'h0100, 14'h0100, 2'b00, 2'b00);
      wait_rises(16);
      set_in(14'h0200, 14'h0200, 2'b00, 2'b00);
      wait (core_sample.data[0] == 14'h0200);
      n0 = rise_cnt + 1;
      while (out_bus.first_channel_bus !== 14'h0200) @(posedge aclk);
      check(32'(rise_cnt - n0), ll ? 32'd10 : 32'd14);
    end
    axi_write(REG_CTRL, 32'h76);
    set_in(14'h1111, 14'h2222, 2'b00, 2'b00);
    wait_rises(14);
    check(32'(out_bus.first_bus_release_n), 32'h1);
    check(32'(a_word), 32'h1111);
    check(32'(b_word), 32'h2222);
    axi_read(REG_STAT_A); check(32'(rd[STAT_MODE_BIT]), 32'h1);
    axi_write(REG_CTRL, 32'h72);
    wait_rises(1);
    check(32'(out_bus.first_bus_release_n), 32'h0);
    control_pin_one <= 1'b1;
    control_pin_two <= 1'b1;
    control_pin_three <= 1'b1;
    serial_enable_pin <= 1'b1;
    axi_write(REG_CTRL, 32'he);
    wait_rises(14);
    check(32'(out_bus.first_bus_release_n), 32'h1);
    check(32'(a_word), 32'h3111);
    check(32'(b_word), 32'h0222);
    control_pin_two <= 1'b0;
    wait_rises(2);
    check(32'(out_bus.first_bus_release_n), 32'h0);
    for (int i = 0; i < 10; i++) begin
      axi_write(REG_CTRL, (i == 9) ? 32'h6 : 32'h4);
      axi_write(REG_FILT, 32'(dflt[i]));
      wait_rises(24);
      n0 = n_words;
      wait_rises(16);
      check(32'(n_words - n0), 32'(dnum[i]));
      if (i < 2) check(32'(out_bus.first_channel_bus), i ? 32'h19b6 : 32'h1114);
    end
    axi_write(REG_CTRL, 32'h4);
    axi_write(REG_FILT, 32'h0);
    axi_write(REG_DSP, 32'h180);
    set_in(14'h2100, 14'h2100, 2'b00, 2'b00);
    wait_rises(30);
    axi_read(REG_STAT_A); check(32'(rd[13:0]), 32'h0);
    check(32'(out_bus.first_channel_bus), 32'h2100);
    tally_and_finish();
  end
endmodule : adc_output_digital_processing_tb_top
bind adc_output_dsp adc_output_dsp_props u_props (.aclk(aclk), .aresetn(aresetn),
  .s_axi_req(s_axi_req), .s_axi_rsp(s_axi_rsp), .out_bus(out_bus),
  .lvds_term_sel(lvds_term_sel));
`default_nettype wire
